//--- hdl/lcm_pkg.sv
// Constants and types of the second-level cache maintenance engine.
// Assumes a 32-bit classic Wishbone slave port and a cache array that
// executes one line operation per request/acknowledge pair.
package lcm_pkg;
    // ========================================================
    // Register map (byte offsets)
    localparam logic [7:0] LCM_OFS_FLUSH_CTL = 8'h00;
    localparam logic [7:0] LCM_OFS_CLEAN_CTL = 8'h04;
    localparam logic [7:0] LCM_OFS_FLUSH_BASE = 8'h10;
    localparam logic [7:0] LCM_OFS_FLUSH_WC = 8'h14;
    localparam logic [7:0] LCM_OFS_CLEAN_BASE = 8'h18;
    localparam logic [7:0] LCM_OFS_CLEAN_WC = 8'h1C;
    localparam logic [7:0] LCM_OFS_STATUS = 8'h20;
    // ========================================================
    // Geometry and reset values
    localparam int LCM_LINE_WORDS = 32;
    localparam int LCM_WOFS_W = 5;
    localparam int LCM_LADDR_W = 25;
    localparam int LCM_INDEX_W = 9;
    localparam logic [LCM_INDEX_W-1:0] LCM_LAST_INDEX = 9'h1FF;
    localparam int LCM_QDEPTH = 4;
    localparam int LCM_QPTR_W = 2;
    localparam logic [2:0] LCM_QFULL = 3'h4;
    localparam logic [31:0] LCM_RST_WORD = 32'h0000_0000;
    localparam logic [5:0] LCM_LINE_WORDS_C = 6'h20;
    // ========================================================
    // Queued range request
    typedef struct packed {
        logic clean;
        logic [29:0] base;
        logic [31:0] count;
    } lcm_range_type;
    // One line operation toward the cache arrays
    typedef struct packed {
        logic whole;
        logic [LCM_LADDR_W-1:0] line;
        logic [LCM_WOFS_W-1:0] first_word;
        logic [LCM_WOFS_W-1:0] last_word;
        logic write_back;
        logic snoop_l1_data;
        logic inv_l1_data;
        logic inv_l1_prog;
        logic inv_l2;
    } lcm_line_op_type;
    typedef enum logic [1:0] {LCM_IDLE, LCM_WHOLE, LCM_RANGE} lcm_state_type;
endpackage

//--- hdl/lcm_maint.sv
// Maintenance engine of the second-level cache: whole and range operations.
// Assumes the cache arrays arbitrate line operations against CPU traffic,
// giving the CPU priority, and write dirty data out via the transfer engine.
module lcm_maint
    import lcm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic line_req_o,
    output lcm_line_op_type line_op_o,
    input wire logic line_ack_i
);
    // ========================================================
    // Helpers
    // Byte-lane merge for a 32-bit register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Words of the current line that fall inside the remaining range
    function automatic logic [5:0] line_words(input logic [29:0] waddr, input logic [31:0] rem);
        logic [5:0] room;
        room = LCM_LINE_WORDS_C - {1'b0, waddr[LCM_WOFS_W-1:0]};
        if (rem < {26'h0, room})
        begin
            return rem[5:0];
        end
        return room;
    endfunction

    // Builds one line operation of a range request
    function automatic lcm_line_op_type range_op(input lcm_range_type r);
        lcm_line_op_type o;
        logic [5:0] n;
        n = line_words(r.base, r.count);
        o.whole = 1'b0;
        o.line = r.base[29:LCM_WOFS_W];
        o.first_word = r.base[LCM_WOFS_W-1:0];
        o.last_word = LCM_WOFS_W'(r.base[LCM_WOFS_W-1:0] + n[LCM_WOFS_W-1:0] - 5'h01);
        o.write_back = 1'b1;
        o.snoop_l1_data = 1'b1;
        o.inv_l1_data = 1'b1;
        o.inv_l1_prog = r.clean;
        o.inv_l2 = r.clean;
        return o;
    endfunction

    // ========================================================
    // State
    logic flush_ctl, next_flush_ctl;
    logic clean_ctl, next_clean_ctl;
    logic whole_is_clean, next_whole_is_clean;
    logic [29:0] flush_base, next_flush_base;
    logic [29:0] clean_base, next_clean_base;
    lcm_range_type queue [LCM_QDEPTH];
    lcm_range_type next_queue [LCM_QDEPTH];
    logic [LCM_QPTR_W-1:0] rd_ptr, next_rd_ptr;
    logic [LCM_QPTR_W-1:0] wr_ptr, next_wr_ptr;
    logic [2:0] q_used, next_q_used;
    lcm_range_type active, next_active;
    logic overflow, next_overflow;
    logic [LCM_INDEX_W-1:0] index, next_index;
    lcm_state_type state, next_state;
    lcm_line_op_type op, next_op;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic wr_cyc, push, pop;
    logic flush_set, clean_set;
    logic [31:0] flush_base_wr, clean_base_wr;
    lcm_range_type pushed;

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign line_req_o = (state != LCM_IDLE);
    assign line_op_o = op;
    // Write strobe: one cycle per classic request, the cycle before ack
    assign wr_cyc = wb_cyc_i && wb_stb_i && !ack && wb_we_i;
    // Byte-merged base words, sliced back to word addresses in the register process
    assign flush_base_wr = merge({flush_base, 2'b00}, wb_dat_i, wb_sel_i);
    assign clean_base_wr = merge({clean_base, 2'b00}, wb_dat_i, wb_sel_i);
    // a written one starts the whole operation
    assign flush_set = wr_cyc && (wb_adr_i == LCM_OFS_FLUSH_CTL) && wb_sel_i[0] && wb_dat_i[0];
    assign clean_set = wr_cyc && (wb_adr_i == LCM_OFS_CLEAN_CTL) && wb_sel_i[0] && wb_dat_i[0];

    // ========================================================
    // Register file and request queue
    // Queue entries are flip-flops; the count write captures the base as
    // it stands, so a later base write cannot disturb a queued request.
    always_comb
    begin
        next_ack = wb_cyc_i && wb_stb_i && !ack;
        next_rdata = LCM_RST_WORD;
        next_flush_base = flush_base;
        next_clean_base = clean_base;
        next_overflow = overflow;
        next_queue = queue;
        next_wr_ptr = wr_ptr;
        push = 1'b0;
        pushed = '0;
        if (wr_cyc)
        begin
            case (wb_adr_i)
                LCM_OFS_FLUSH_BASE: next_flush_base = flush_base_wr[31:2];
                LCM_OFS_CLEAN_BASE: next_clean_base = clean_base_wr[31:2];
                LCM_OFS_FLUSH_WC, LCM_OFS_CLEAN_WC:
                begin
                    pushed.clean = (wb_adr_i == LCM_OFS_CLEAN_WC);
                    pushed.base = pushed.clean ? clean_base : flush_base;
                    pushed.count = merge(LCM_RST_WORD, wb_dat_i, wb_sel_i);
                    push = (pushed.count != LCM_RST_WORD) && (q_used != LCM_QFULL);
                    next_overflow = overflow || ((pushed.count != LCM_RST_WORD) && (q_used == LCM_QFULL));
                end
                LCM_OFS_STATUS: next_overflow = overflow && !wb_dat_i[0];
                default: next_overflow = overflow;
            endcase
        end
        if (push)
        begin
            next_queue[wr_ptr] = pushed;
            next_wr_ptr = LCM_QPTR_W'(wr_ptr + 2'h1);
        end
        if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i)
        begin
            case (wb_adr_i)
                LCM_OFS_FLUSH_CTL: next_rdata = {31'h0, flush_ctl};
                LCM_OFS_CLEAN_CTL: next_rdata = {31'h0, clean_ctl};
                LCM_OFS_FLUSH_BASE: next_rdata = {flush_base, 2'b00};
                LCM_OFS_CLEAN_BASE: next_rdata = {clean_base, 2'b00};
                LCM_OFS_FLUSH_WC, LCM_OFS_CLEAN_WC: next_rdata = active.count;
                LCM_OFS_STATUS: next_rdata = {26'h0, q_used, state == LCM_RANGE, state == LCM_WHOLE, overflow};
                default: next_rdata = LCM_RST_WORD;
            endcase
        end
    end

    // ========================================================
    // Engine: whole-cache walk and range walk, one line at a time
    always_comb
    begin
        next_state = state;
        next_index = index;
        next_active = active;
        next_rd_ptr = rd_ptr;
        next_op = op;
        next_flush_ctl = flush_ctl;
        next_clean_ctl = clean_ctl;
        next_whole_is_clean = whole_is_clean;
        pop = 1'b0;
        if (flush_set)
        begin
            next_flush_ctl = 1'b1;
        end
        if (clean_set)
        begin
            next_clean_ctl = 1'b1;
        end
        case (state)
            LCM_IDLE:
            begin
                // Whole operations first; a clean covers a pending flush
                if (flush_ctl || clean_ctl)
                begin
                    next_state = LCM_WHOLE;
                    next_index = '0;
                    next_whole_is_clean = clean_ctl;
                    next_op = '{whole: 1'b1, line: '0, first_word: '0, last_word: 5'h1F, write_back: 1'b1,
                        snoop_l1_data: 1'b1, inv_l1_data: 1'b1, inv_l1_prog: clean_ctl, inv_l2: clean_ctl};
                end
                else if (q_used != 3'h0)
                begin
                    pop = 1'b1;
                    next_rd_ptr = LCM_QPTR_W'(rd_ptr + 2'h1);
                    next_active = queue[rd_ptr];
                    next_op = range_op(queue[rd_ptr]);
                    next_state = LCM_RANGE;
                end
            end
            LCM_WHOLE:
            begin
                if (line_ack_i)
                begin
                    next_index = LCM_INDEX_W'(index + 9'h001);
                    next_op.line = LCM_LADDR_W'(next_index);
                    if (index == LCM_LAST_INDEX)
                    begin
                        // cleared only when the walk ends; a write of one in this cycle wins
                        next_state = LCM_IDLE;
                        next_flush_ctl = flush_set;
                        // A clean asked for during a whole flush still waits its turn
                        next_clean_ctl = whole_is_clean ? clean_set : next_clean_ctl;
                    end
                end
            end
            LCM_RANGE:
            begin
                if (line_ack_i)
                begin
                    // advance by words covered in this line
                    next_active.count = active.count - {26'h0, line_words(active.base, active.count)};
                    next_active.base = 30'(active.base + {24'h0, line_words(active.base, active.count)});
                    next_op = range_op(next_active);
                    if (next_active.count == LCM_RST_WORD)
                    begin
                        // reload from queue or hold zero
                        if (q_used != 3'h0 && !flush_ctl && !clean_ctl)
                        begin
                            pop = 1'b1;
                            next_rd_ptr = LCM_QPTR_W'(rd_ptr + 2'h1);
                            next_active = queue[rd_ptr];
                            next_op = range_op(queue[rd_ptr]);
                        end
                        else
                        begin
                            next_state = LCM_IDLE;
                        end
                    end
                end
            end
            default: next_state = LCM_IDLE;
        endcase
        next_q_used = 3'(q_used + {2'h0, push} - {2'h0, pop});
    end

    // ========================================================
    // Registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            rdata <= LCM_RST_WORD;
            flush_ctl <= 1'b0;
            clean_ctl <= 1'b0;
            whole_is_clean <= 1'b0;
            flush_base <= '0;
            clean_base <= '0;
            queue <= '{default: '0};
            rd_ptr <= '0;
            wr_ptr <= '0;
            q_used <= '0;
            active <= '0;
            overflow <= 1'b0;
            index <= '0;
            state <= LCM_IDLE;
            op <= '0;
        end
        else
        begin
            ack <= next_ack;
            rdata <= next_rdata;
            flush_ctl <= next_flush_ctl;
            clean_ctl <= next_clean_ctl;
            whole_is_clean <= next_whole_is_clean;
            flush_base <= next_flush_base;
            clean_base <= next_clean_base;
            queue <= next_queue;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            q_used <= next_q_used;
            active <= next_active;
            overflow <= next_overflow;
            index <= next_index;
            state <= next_state;
            op <= next_op;
        end
    end

    // ========================================================
    // Assertions
    sequence count_write_s;
        wr_cyc && (wb_adr_i == LCM_OFS_FLUSH_WC) && wb_dat_i != 32'h0 && wb_sel_i == 4'hF && q_used == 3'h0
            && !flush_ctl && !clean_ctl && state == LCM_IDLE;
    endsequence
    sequence range_starts_s;
        ##2 (state == LCM_RANGE && line_req_o && !op.whole);
    endsequence

    wb_ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    flush_start_a: assert property (@(posedge clk_i) disable iff (rst_i) count_write_s |-> range_starts_s)
        else $error("range flush did not start two cycles after count write");
    clean_bit_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == LCM_WHOLE && whole_is_clean) |-> clean_ctl)
        else $error("clean bit dropped during whole clean");
    flush_bit_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == LCM_WHOLE && !whole_is_clean) |-> flush_ctl)
        else $error("flush bit dropped during whole flush");
    whole_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == LCM_WHOLE && line_ack_i && index == LCM_LAST_INDEX && whole_is_clean && !clean_set) |=> !clean_ctl)
        else $error("clean bit not cleared at end of walk");
    prog_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (line_req_o && op.whole && !whole_is_clean) |-> !op.inv_l1_prog && !op.inv_l2)
        else $error("whole flush touched program cache or second level valid");
    clean_inv_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == LCM_RANGE && active.clean) |-> op.inv_l1_prog && op.inv_l1_data && op.inv_l2)
        else $error("range clean without invalidation");
    mask_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == LCM_RANGE) |-> op.first_word == active.base[4:0] && op.last_word >= op.first_word)
        else $error("write mask does not start at range word");
    count_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == LCM_RANGE && $past(state) == LCM_RANGE) |-> active.count != 32'h0)
        else $error("active count zero while range walk runs");
    queue_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pop |=> active == $past(queue[rd_ptr]))
        else $error("queued request not taken from head");
endmodule

//--- testbench/lcm_cache_model.sv
// Stand-in for the cache arrays that accept the engine's line operations.
// Assumes a request level from the engine and a one-cycle acknowledge pulse.
module lcm_cache_model
    import lcm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_req_i,
    input wire logic [7:0] delay_i,
    output logic line_ack_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] wait_cnt;
    // ========================================================
    // Acknowledge pacing
    // CPU wins arrays
    // The delay stands for CPU traffic taking the arrays first, so the engine has to wait
    always_ff @(posedge clk_i)
    begin
        if (rst_i || line_ack_o || !line_req_i)
        begin
            line_ack_o <= 1'b0;
            wait_cnt <= 8'h00;
        end
        else if (wait_cnt >= delay_i)
            line_ack_o <= 1'b1;
        else
            wait_cnt <= wait_cnt + 8'h01;
    end
endmodule

//--- testbench/lcm_maint_test.sv
// Self-checking bench of the cache maintenance engine.
// Assumes a Wishbone answer one cycle after the request and a cache model.
module lcm_maint_test
    import lcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic we; logic [7:0] adr; logic [31:0] dat; logic [31:0] exp;} lcm_row_type;
    localparam lcm_row_type ROWS [9] = '{
        '{1'b0, LCM_OFS_FLUSH_CTL, 32'h0, 32'h0}, '{1'b0, LCM_OFS_CLEAN_CTL, 32'h0, 32'h0},
        '{1'b0, LCM_OFS_FLUSH_WC, 32'h0, 32'h0}, '{1'b0, LCM_OFS_CLEAN_WC, 32'h0, 32'h0},
        '{1'b0, LCM_OFS_STATUS, 32'h0, 32'h0}, '{1'b1, 8'h0C, 32'h5A5A_A5A5, 32'h0},
        '{1'b1, 8'h24, 32'hFFFF_FFFF, 32'h0}, '{1'b1, LCM_OFS_FLUSH_WC, 32'h0, 32'h0},
        '{1'b0, LCM_OFS_STATUS, 32'h0, 32'h0}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic line_req;
    logic line_ack;
    logic [7:0] delay = 8'h00;
    lcm_line_op_type line_op;
    lcm_line_op_type ops [$];
    logic [31:0] q;
    int lat;
    int n_mismatch = 0;
    int samples_checked = 0;
    lcm_maint uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .line_req_o(line_req), .line_op_o(line_op), .line_ack_i(line_ack));
    lcm_cache_model model (.clk_i(clk_i), .rst_i(rst_i), .line_req_i(line_req), .delay_i(delay),
        .line_ack_o(line_ack));
    // ========================================================
    // Clock, watchdog and operation log
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end
    // Each accepted line operation is logged at its acknowledge edge
    always @(posedge clk_i)
    begin
        if (line_req === 1'b1 && line_ack === 1'b1)
            ops.push_back(line_op);
    end
    // ========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        lat = 0;
        do
        begin
            @(posedge clk_i);
            lat++;
        end
        while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk({31'h0, ack}, 32'h1);
    endtask
    // Software polling until the register holds zero and the engine rests
    task automatic poll(input logic [7:0] a);
        int k;
        k = 0;
        do
        begin
            wb(1'b0, a, 32'h0, q);
            k++;
        end
        while ((q !== 32'h0 || line_req !== 1'b0) && k < 2000);
        chk(q, 32'h0);
    endtask
    // Flag pattern {whole, write_back, snoop, inv_l1_data, inv_l1_prog, inv_l2} of every logged op
    task automatic scan(input int n, input logic [5:0] f);
        int bad;
        bad = 0;
        foreach (ops[i])
            if ({ops[i].whole, ops[i].write_back, ops[i].snoop_l1_data, ops[i].inv_l1_data,
                ops[i].inv_l1_prog, ops[i].inv_l2} !== f)
                bad++;
        chk(32'(ops.size()), 32'(n));
        chk(32'(bad), 32'h0);
    endtask
    // Upper line bits stay zero in these scenarios, so a slice is enough
    function automatic logic [31:0] opw(input int i);
        return {ops[i].inv_l2, ops[i].line[20:0], ops[i].first_word, ops[i].last_word};
    endfunction
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ROWS[i])
        begin
            if (ROWS[i].we)
                wb(1'b1, ROWS[i].adr, ROWS[i].dat, q);
            wb(1'b0, ROWS[i].adr, 32'h0, q);
            chk(q, ROWS[i].exp);
        end
        delay <= 8'h03;
        wb(1'b1, LCM_OFS_FLUSH_BASE, 32'h0000_1000, q);
        wb(1'b1, LCM_OFS_FLUSH_WC, 32'h0000_0040, q);
        wb(1'b0, LCM_OFS_FLUSH_WC, 32'h0, q);
        chk({31'h0, q !== 32'h0}, 32'h1);
        chk(32'(lat), 32'h2);
        poll(LCM_OFS_FLUSH_WC);
        scan(2, 6'h1C);
        chk(opw(0), {1'b0, 21'h20, 5'h00, 5'h1F});
        chk(opw(1), {1'b0, 21'h21, 5'h00, 5'h1F});
        ops.delete();
        wb(1'b1, LCM_OFS_CLEAN_BASE, 32'h0000_2010, q);
        wb(1'b1, LCM_OFS_CLEAN_WC, 32'h0000_0028, q);
        chk(32'(lat), 32'h2);
        poll(LCM_OFS_CLEAN_WC);
        scan(2, 6'h1F);
        chk(opw(0), {1'b1, 21'h40, 5'h04, 5'h1F});
        chk(opw(1), {1'b1, 21'h41, 5'h00, 5'h0B});
        ops.delete();
        delay <= 8'h06;
        wb(1'b1, LCM_OFS_FLUSH_BASE, 32'h0000_3000, q);
        wb(1'b1, LCM_OFS_FLUSH_WC, 32'h0000_0020, q);
        wb(1'b1, LCM_OFS_CLEAN_BASE, 32'h0000_4000, q);
        wb(1'b1, LCM_OFS_CLEAN_WC, 32'h0000_0020, q);
        wb(1'b1, LCM_OFS_FLUSH_BASE, 32'h0000_5000, q);
        wb(1'b1, LCM_OFS_FLUSH_WC, 32'h0000_0020, q);
        poll(LCM_OFS_FLUSH_WC);
        wb(1'b0, LCM_OFS_CLEAN_WC, 32'h0, q);
        chk(q, 32'h0);
        chk(32'(ops.size()), 32'h3);
        chk(opw(0), {1'b0, 21'h60, 5'h00, 5'h1F});
        chk(opw(1), {1'b1, 21'h80, 5'h00, 5'h1F});
        chk(opw(2), {1'b0, 21'hA0, 5'h00, 5'h1F});
        ops.delete();
        delay <= 8'h00;
        wb(1'b1, LCM_OFS_FLUSH_CTL, 32'h0000_0001, q);
        wb(1'b0, LCM_OFS_FLUSH_CTL, 32'h0, q);
        chk(q & 32'h1, 32'h1);
        poll(LCM_OFS_FLUSH_CTL);
        scan(512, 6'h3C);
        chk(32'(ops[511].line[8:0]), 32'(LCM_LAST_INDEX));
        ops.delete();
        wb(1'b1, LCM_OFS_CLEAN_CTL, 32'h0000_0001, q);
        wb(1'b0, LCM_OFS_CLEAN_CTL, 32'h0, q);
        chk(q & 32'h1, 32'h1);
        poll(LCM_OFS_CLEAN_CTL);
        scan(512, 6'h3F);
        // Six counts behind one slow line: four queue, the sixth is dropped and flagged
        ops.delete();
        delay <= 8'h40;
        wb(1'b1, LCM_OFS_FLUSH_BASE, 32'h0000_6000, q);
        repeat (6) wb(1'b1, LCM_OFS_FLUSH_WC, 32'h0000_0001, q);
        wb(1'b0, LCM_OFS_STATUS, 32'h0, q);
        chk(q, 32'h0000_0025);
        wb(1'b1, LCM_OFS_STATUS, 32'h0000_0001, q);
        wb(1'b0, LCM_OFS_STATUS, 32'h0, q);
        chk(q, 32'h0000_0024);
        poll(LCM_OFS_FLUSH_WC);
        chk(32'(ops.size()), 32'h5);
        delay <= 8'h00;
        // Reset in mid-walk must drop the request and the control bit
        wb(1'b1, LCM_OFS_CLEAN_CTL, 32'h0000_0001, q);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, line_req}, 32'h0);
        wb(1'b0, LCM_OFS_CLEAN_CTL, 32'h0, q);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule
